// ==== design/hub_port_pkg.sv ====
// Shared constants for the downstream port control block: register map,
// configuration fields, request codes, indicator selectors, timing counts.
// Assumes a single 125 MHz clock and an APB register bus with 32-bit data.
package hub_port_pkg;
   localparam int NPORT = 4;
   // Register byte offsets
   localparam logic [7:0] CFG_OFS  = 8'h00;
   localparam logic [7:0] CMD_OFS  = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] CHG_OFS  = 8'h0c;
   localparam logic [7:0] INFO_OFS = 8'h10;
   // Configuration register fields
   localparam int CFG_CONF    = 0;
   localparam int CFG_GANGED  = 1;
   localparam int CFG_PWR_HI  = 2;
   localparam int CFG_OVR_HI  = 3;
   localparam int CFG_IND_LOW = 4;
   localparam int CFG_IND_DIS = 5;
   localparam int CFG_MOD_EN  = 6;
   localparam int CFG_OCEN    = 8;
   localparam int CFG_OCDIS   = 12;
   localparam int CFG_REMOV   = 16;
   localparam int CFG_USABLE  = 20;
   localparam logic [31:0] CFG_RST = 32'h00ff_8800;
   // Command register fields and request codes
   localparam int CMD_PORT = 4;
   localparam int CMD_SEL  = 8;
   localparam logic [3:0] REQ_SET_POWER   = 4'h1;
   localparam logic [3:0] REQ_CLR_POWER   = 4'h2;
   localparam logic [3:0] REQ_SET_RESET   = 4'h3;
   localparam logic [3:0] REQ_CLR_ENABLE  = 4'h4;
   localparam logic [3:0] REQ_SET_SUSPEND = 4'h5;
   localparam logic [3:0] REQ_CLR_SUSPEND = 4'h6;
   localparam logic [3:0] REQ_SET_IND     = 4'h7;
   // Indicator selectors
   localparam logic [2:0] IND_AUTO  = 3'h0;
   localparam logic [2:0] IND_AMBER = 3'h1;
   localparam logic [2:0] IND_GREEN = 3'h2;
   localparam logic [2:0] IND_OFF   = 3'h3;
   localparam logic [2:0] IND_BL_OG = 3'h4;
   localparam logic [2:0] IND_BL_OA = 3'h5;
   localparam logic [2:0] IND_BL_GA = 3'h6;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PORT_RESET_MS = 4'ha;
   localparam logic [8:0] BLINK_MS      = 9'h1f4;
   typedef enum logic [2:0] {PS_OFF, PS_DISC, PS_DIS, PS_RST, PS_ENA, PS_SUSP} port_state_t;
   // Apply a configurable active polarity
   function automatic logic act(input logic v, input logic hi);
      return hi ? v : ~v;
   endfunction
endpackage

// ==== design/hub_port_ctrl.sv ====
// Downstream port control of a four-port hub: port states, power switch
// enables, filtered overcurrent, indicators, APB register access.
// Assumes line status, frame timing and hub state come from the SIE/repeater.
`timescale 1ns/100ps
module hub_port_ctrl
   import hub_port_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // APB slave
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Hub context
   input  wire logic        bus_reset_i,
   input  wire logic        hub_suspended_i,
   input  wire logic        past_eof2_i,
   input  wire logic        upstream_tx_active_i,
   input  wire logic        hs_negotiated_i,
   // Downstream line status
   input  wire logic [3:0]  dev_connected_i,
   input  wire logic [3:0]  line_idle_i,
   input  wire logic [3:0]  remote_wake_i,
   // Downstream drive
   output logic      [3:0]  se0_drive_o,
   output logic      [3:0]  port_reset_o,
   // Upstream side
   output logic             up_speed_hs_o,
   output logic             up_resume_o,
   output logic             up_fault_o,
   output logic      [4:0]  status_change_o,
   output logic      [15:0] hub_char_o,
   // Power switch
   output logic      [3:0]  port_power_enable_n_o,
   input  wire logic [3:0]  port_overcurrent_sense_n_i,
   // Indicators
   output logic      [3:0]  led_green_o,
   output logic      [3:0]  led_amber_o
);

   port_state_t state_ff  [NPORT];
   port_state_t nxt_state [NPORT];
   logic [3:0]  oc_cnt_ff [NPORT];
   logic [3:0]  nxt_oc_cnt[NPORT];
   logic [3:0]  oc_thr    [NPORT];
   logic [3:0]  tmr_ff    [NPORT];
   logic [3:0]  nxt_tmr   [NPORT];
   logic [2:0]  ind_sel_ff[NPORT];
   logic [2:0]  nxt_ind   [NPORT];
   logic [31:0] cfg_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_mux;
   logic [31:0] stat_word;
   logic [15:0] chg_ff;
   logic [15:0] chg_set;
   logic [16:0] ms_cnt_ff;
   logic [8:0]  blink_cnt_ff;
   logic        blink_ff;
   logic        ms_tick;
   logic [3:0]  arm_ff, nxt_arm;
   logic [3:0]  oc_ff, nxt_oc;
   logic [3:0]  oc_in, oc_det;
   logic [3:0]  pwr_ff, led_g_ff, led_a_ff, se0_ff, rst_ff;
   logic [3:0]  nxt_pwr, nxt_led_g, nxt_led_a;
   logic [3:0]  babble, disc_evt, wake_fwd;
   logic [3:0]  cmd_hit, pwr_hit, usable;
   logic        up_resume_ff, up_fault_ff, hs_ff;

   // APB decode
   wire         apb_access = psel_i & penable_i;
   wire         apb_setup  = psel_i & ~penable_i;
   wire         apb_wr     = apb_access & pwrite_i;
   wire         hit_cfg    = paddr_i == CFG_OFS;
   wire         hit_cmd    = paddr_i == CMD_OFS;
   wire         hit_stat   = paddr_i == STAT_OFS;
   wire         hit_chg    = paddr_i == CHG_OFS;
   wire         hit_info   = paddr_i == INFO_OFS;
   wire         mapped     = hit_cfg | hit_cmd | hit_stat | hit_chg | hit_info;
   wire         cmd_wr     = apb_wr & hit_cmd;
   wire [3:0]   req        = pwdata_i[3:0];
   wire         configured = cfg_ff[CFG_CONF];
   wire         ganged     = cfg_ff[CFG_GANGED];
   wire [3:0]   removable  = cfg_ff[CFG_REMOV +: 4];
   wire         ind_dis    = cfg_ff[CFG_IND_DIS];
   wire         lit        = ~ind_dis & (~cfg_ff[CFG_MOD_EN] | ms_cnt_ff[2]);

   assign pready_o  = 1'b1;
   assign pslverr_o = apb_access & ~mapped;
   assign prdata_o  = prdata_ff;

   // Request targeting: power requests reach all ports when ganged
   assign usable  = cfg_ff[CFG_USABLE +: 4];
   assign cmd_hit = cmd_wr ? (4'h1 << pwdata_i[CMD_PORT +: 2]) : 4'h0;
   assign pwr_hit = ganged ? {4{|cmd_hit}} : cmd_hit;

   // Millisecond tick and blink timebase
   assign ms_tick = ms_cnt_ff == 17'(MS_CYCLES_P - 1);

   // Descriptor characteristics word and status change bitmap
   assign hub_char_o = {8'h00, ~ind_dis, 3'b000, ~ganged, 2'b00, ~ganged};
   assign status_change_o = {chg_ff[15:12] | chg_ff[11:8] | chg_ff[7:4] | chg_ff[3:0], 1'b0};

   // Overcurrent sense, filter count and detection
   always_comb
   begin
      for (int i = 0; i < NPORT; i++)
      begin
         oc_in[i]  = act(port_overcurrent_sense_n_i[i], cfg_ff[CFG_OVR_HI]);
         oc_thr[i] = (state_ff[i] == PS_ENA) ? cfg_ff[CFG_OCEN +: 4]
                                             : cfg_ff[CFG_OCDIS +: 4];
         oc_det[i] = oc_in[i] && (state_ff[i] != PS_OFF) && (oc_cnt_ff[i] >= oc_thr[i]);
         if (!oc_in[i])
            nxt_oc_cnt[i] = 4'h0;
         else if (ms_tick && oc_cnt_ff[i] != 4'hf)
            nxt_oc_cnt[i] = oc_cnt_ff[i] + 4'h1;
         else
            nxt_oc_cnt[i] = oc_cnt_ff[i];
      end
   end

   // Port state machines
   always_comb
   begin
      chg_set = 16'h0000;
      for (int i = 0; i < NPORT; i++)
      begin
         nxt_state[i] = state_ff[i];
         nxt_tmr[i]   = tmr_ff[i];
         nxt_arm[i]   = arm_ff[i];
         nxt_oc[i]    = oc_ff[i];
         babble[i]    = 1'b0;
         disc_evt[i]  = 1'b0;
         wake_fwd[i]  = 1'b0;
         if (!configured || !usable[i])
         begin
            nxt_state[i] = PS_OFF;
            nxt_arm[i]   = 1'b0;
            nxt_oc[i]    = 1'b0;
         end
         else if (oc_det[i] || (ganged && |oc_det))
         begin
            nxt_state[i]  = PS_OFF;
            nxt_oc[i]     = 1'b1;
            nxt_arm[i]    = 1'b0;
            chg_set[12+i] = 1'b1;
         end
         else if (pwr_hit[i] && req == REQ_CLR_POWER)
         begin
            nxt_state[i] = PS_OFF;
            nxt_arm[i]   = 1'b0;
         end
         else
         begin
            case (state_ff[i])
               PS_OFF:
                  if (pwr_hit[i] && req == REQ_SET_POWER)
                  begin
                     nxt_state[i] = PS_DISC;
                     nxt_oc[i]    = 1'b0;
                  end
               PS_DISC:
                  if (dev_connected_i[i])
                  begin
                     nxt_state[i] = PS_DIS;
                     chg_set[i]   = 1'b1;
                  end
               PS_DIS, PS_RST, PS_ENA, PS_SUSP:
                  if (!dev_connected_i[i])
                  begin
                     nxt_state[i] = PS_DISC;
                     nxt_arm[i]   = 1'b0;
                     chg_set[i]   = 1'b1;
                     disc_evt[i]  = 1'b1;
                  end
                  else if (state_ff[i] == PS_DIS)
                  begin
                     if (cmd_hit[i] && req == REQ_SET_RESET)
                     begin
                        nxt_state[i] = PS_RST;
                        nxt_tmr[i]   = 4'h0;
                     end
                  end
                  else if (state_ff[i] == PS_RST)
                  begin
                     if (ms_tick && tmr_ff[i] == PORT_RESET_MS - 4'h1)
                        nxt_state[i] = PS_ENA;
                     else if (ms_tick)
                        nxt_tmr[i] = tmr_ff[i] + 4'h1;
                  end
                  else if (state_ff[i] == PS_ENA)
                  begin
                     nxt_arm[i] = 1'b1;
                     if (arm_ff[i] && past_eof2_i && !line_idle_i[i])
                     begin
                        nxt_state[i] = PS_DIS;
                        nxt_arm[i]   = 1'b0;
                        babble[i]    = 1'b1;
                        chg_set[4+i] = 1'b1;
                     end
                     else if (cmd_hit[i] && req == REQ_CLR_ENABLE)
                     begin
                        nxt_state[i] = PS_DIS;
                        nxt_arm[i]   = 1'b0;
                     end
                     else if (cmd_hit[i] && req == REQ_SET_SUSPEND)
                        nxt_state[i] = PS_SUSP;
                  end
                  else
                  begin
                     if (cmd_hit[i] && req == REQ_CLR_ENABLE)
                     begin
                        nxt_state[i] = PS_DIS;
                        nxt_arm[i]   = 1'b0;
                     end
                     else if (cmd_hit[i] && req == REQ_CLR_SUSPEND)
                        nxt_state[i] = PS_ENA;
                     else if (remote_wake_i[i])
                     begin
                        nxt_state[i] = PS_ENA;
                        if (hub_suspended_i)
                           wake_fwd[i] = 1'b1;
                        else
                           chg_set[8+i] = 1'b1;
                     end
                  end
               default:
                  nxt_state[i] = PS_OFF;
            endcase
         end
         nxt_pwr[i] = act(nxt_state[i] != PS_OFF, cfg_ff[CFG_PWR_HI]);
      end
   end

   // Indicator colour selection and output polarity
   always_comb
   begin
      for (int i = 0; i < NPORT; i++)
      begin
         nxt_led_g[i] = 1'b0;
         nxt_led_a[i] = 1'b0;
         case (ind_sel_ff[i])
            IND_AUTO:
            begin
               nxt_led_g[i] = state_ff[i] == PS_ENA;
               nxt_led_a[i] = oc_ff[i] && state_ff[i] == PS_OFF;
            end
            IND_AMBER: nxt_led_a[i] = 1'b1;
            IND_GREEN: nxt_led_g[i] = 1'b1;
            IND_BL_OG: nxt_led_g[i] = blink_ff;
            IND_BL_OA: nxt_led_a[i] = blink_ff;
            IND_BL_GA:
            begin
               nxt_led_g[i] = blink_ff;
               nxt_led_a[i] = ~blink_ff;
            end
            default: nxt_led_g[i] = 1'b0;
         endcase
         nxt_led_g[i] = act(nxt_led_g[i] & lit, ~cfg_ff[CFG_IND_LOW]);
         nxt_led_a[i] = act(nxt_led_a[i] & lit, ~cfg_ff[CFG_IND_LOW]);
         nxt_ind[i]   = (!configured) ? IND_AUTO :
                        (cmd_hit[i] && req == REQ_SET_IND) ? pwdata_i[CMD_SEL +: 3] :
                        ind_sel_ff[i];
      end
   end

   // Read data multiplexer
   always_comb
   begin
      for (int i = 0; i < NPORT; i++)
         stat_word[i*8 +: 8] = {oc_ff[i], arm_ff[i], dev_connected_i[i], 2'b00,
                                state_ff[i]};
      rd_mux = hit_cfg  ? cfg_ff :
               hit_stat ? stat_word :
               hit_chg  ? {16'h0000, chg_ff} :
               hit_info ? {8'h00, 3'b000, hs_ff, removable, hub_char_o} :
               32'h0000_0000;
   end

   // Configuration register; bus reset drops the configured bit
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         cfg_ff <= CFG_RST;
      else if (bus_reset_i)
         cfg_ff[CFG_CONF] <= 1'b0;
      else if (apb_wr && hit_cfg)
         cfg_ff <= pwdata_i;
   end

   // Read data capture and sticky change bits, set beats clear
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         prdata_ff <= 32'h0000_0000;
         chg_ff    <= 16'h0000;
      end
      else
      begin
         if (apb_setup && !pwrite_i)
            prdata_ff <= rd_mux;
         chg_ff <= (chg_ff & ~((apb_wr && hit_chg) ? pwdata_i[15:0] : 16'h0000))
                   | chg_set;
      end
   end

   // Time bases
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         ms_cnt_ff    <= 17'h00000;
         blink_cnt_ff <= 9'h000;
         blink_ff     <= 1'b0;
      end
      else
      begin
         ms_cnt_ff <= ms_tick ? 17'h00000 : ms_cnt_ff + 17'h00001;
         if (ms_tick)
         begin
            blink_cnt_ff <= (blink_cnt_ff == BLINK_MS - 9'h001) ? 9'h000
                                                                : blink_cnt_ff + 9'h001;
            if (blink_cnt_ff == BLINK_MS - 9'h001)
               blink_ff <= ~blink_ff;
         end
      end
   end

   // Per-port state registers
   always_ff @(posedge mclk_i)
   begin
      for (int i = 0; i < NPORT; i++)
      begin
         if (srst_i)
         begin
            state_ff[i]   <= PS_OFF;
            oc_cnt_ff[i]  <= 4'h0;
            tmr_ff[i]     <= 4'h0;
            ind_sel_ff[i] <= IND_AUTO;
         end
         else
         begin
            state_ff[i]   <= nxt_state[i];
            oc_cnt_ff[i]  <= nxt_oc_cnt[i];
            tmr_ff[i]     <= nxt_tmr[i];
            ind_sel_ff[i] <= nxt_ind[i];
         end
      end
   end

   // Registered pin outputs and upstream signalling
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         arm_ff <= 4'h0; oc_ff <= 4'h0; pwr_ff <= 4'hf;
         led_g_ff <= 4'h0; led_a_ff <= 4'h0; se0_ff <= 4'hf; rst_ff <= 4'h0;
         up_resume_ff <= 1'b0; up_fault_ff <= 1'b0; hs_ff <= 1'b0;
      end
      else
      begin
         arm_ff   <= nxt_arm;
         oc_ff    <= nxt_oc;
         pwr_ff   <= nxt_pwr;
         led_g_ff <= nxt_led_g;
         led_a_ff <= nxt_led_a;
         se0_ff   <= configured ? 4'h0 : 4'hf;
         for (int i = 0; i < NPORT; i++)
            rst_ff[i] <= nxt_state[i] == PS_RST;
         up_resume_ff <= |wake_fwd;
         up_fault_ff  <= |(babble | disc_evt) & ~upstream_tx_active_i;
         hs_ff        <= hs_negotiated_i;
      end
   end

   assign port_power_enable_n_o = pwr_ff;
   assign led_green_o           = led_g_ff;
   assign led_amber_o           = led_a_ff;
   assign se0_drive_o           = se0_ff;
   assign port_reset_o          = rst_ff;
   assign up_resume_o           = up_resume_ff;
   assign up_fault_o            = up_fault_ff;
   assign up_speed_hs_o         = hs_ff;

   // Checks on port 0
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   wire ok0 = configured & usable[0] & ~(|oc_det);

   preconf_se0_a: assert property (!configured |=> se0_drive_o == 4'hf && state_ff[0] == PS_OFF)
      else $error("ports not held in SE0 before configuration");
   power_on_a: assert property (ok0 && state_ff[0] == PS_OFF && pwr_hit[0]
                                && req == REQ_SET_POWER |=> state_ff[0] == PS_DISC)
      else $error("set power did not power the port");
   conn_report_a: assert property (ok0 && state_ff[0] == PS_DISC && dev_connected_i[0]
                                   && !pwr_hit[0] |=> chg_ff[0] && status_change_o[1])
      else $error("connect not reported");
   reset_arm_a: assert property (state_ff[0] == PS_ENA && $past(state_ff[0]) == PS_RST
                                 |-> !arm_ff[0] ##1 (arm_ff[0] || state_ff[0] != PS_ENA))
      else $error("babble detection not armed after enable");
   babble_off_a: assert property (ok0 && state_ff[0] == PS_ENA && arm_ff[0] && past_eof2_i
                                  && !line_idle_i[0] && dev_connected_i[0] && !pwr_hit[0]
                                  |=> state_ff[0] == PS_DIS ##1 !port_reset_o[0])
      else $error("babble did not disable the port");
   clr_enable_a: assert property (ok0 && state_ff[0] == PS_ENA && cmd_hit[0] && req ==
                                  REQ_CLR_ENABLE |=> state_ff[0] != PS_ENA)
      else $error("clear enable ignored");
   wake_fwd_a: assert property (ok0 && state_ff[0] == PS_SUSP && dev_connected_i[0]
                                && !cmd_hit[0] && !pwr_hit[0] && remote_wake_i[0]
                                && hub_suspended_i |=> up_resume_o)
      else $error("wakeup not forwarded upstream");
   fault_block_a: assert property (upstream_tx_active_i |=> !up_fault_o)
      else $error("downstream fault passed while repeating");
   oc_power_a: assert property (configured && oc_det[0]
                                |=> port_power_enable_n_o[0] == ~cfg_ff[CFG_PWR_HI]
                                    && oc_ff[0] ##1 chg_ff[12] || $past(chg_set[12]))
      else $error("overcurrent kept power on");
   auto_green_a: assert property (ind_sel_ff[0] == IND_AUTO && state_ff[0] == PS_ENA
                                  && !ind_dis && !cfg_ff[CFG_MOD_EN] && $stable(cfg_ff)
                                  |=> led_green_o[0] == ~cfg_ff[CFG_IND_LOW])
      else $error("auto indicator not green on enabled port");

   babble_c: cover property (babble[0]);
   oc_c: cover property (oc_det[0] ##1 state_ff[0] == PS_OFF);
   reset_done_c: cover property (state_ff[0] == PS_RST ##1 state_ff[0] == PS_ENA);
   wake_c: cover property (|wake_fwd);

endmodule // hub_port_ctrl

// ==== testbench/hub_dev_model.sv ====
// Device and power switch model on the pin side of the port block.
// Assumes active-low power enables and fault outputs.
`timescale 1ns/100ps
module hub_dev_model (
   // Hub pins
   input  wire logic [3:0] port_power_enable_n_i,
   output logic      [3:0] dev_connected_o,
   output logic      [3:0] port_overcurrent_sense_n_o,
   // Scenario controls
   input  wire logic [3:0] attach_i,
   input  wire logic [3:0] fault_i
);
   // A device shows up only on a powered port
   assign dev_connected_o = attach_i & ~port_power_enable_n_i;
   // The switch flags a fault only while it supplies power
   assign port_overcurrent_sense_n_o = ~(fault_i & ~port_power_enable_n_i);
endmodule // hub_dev_model

// ==== testbench/tb_hub_downstream_port_control.sv ====
// Self-checking bench for the port block over APB.
// Assumes 16-cycle ms ticks and default configuration polarities.
`timescale 1ns/100ps
module tb_hub_downstream_port_control
   import hub_port_pkg::*;
;
   logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        bus_rst = 0, eof2 = 0, pready, pslverr, e;
   logic        hsus = 0, utx = 0, hs = 1, upres, upflt, uhs;
   logic [3:0]  wake = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [3:0]  idle = 4'hf, att = 0, flt = 0, conn, ocn, pwrn;
   logic [3:0]  se0, prst, lg, la;
   logic [4:0]  chg;
   logic [15:0] hch;
   int          bad_count = 0, samples_checked = 0;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
   row_t rows[4] = '{'{CFG_OFS, CFG_RST, 0}, '{CMD_OFS, 0, 0},
                     '{8'h14, 0, 1}, '{8'h02, 0, 1}};
   // Clock
   always #4 mclk = ~mclk;
   hub_port_ctrl #(.MS_CYCLES_P(16)) i_dut (.mclk_i(mclk), .srst_i(srst),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .bus_reset_i(bus_rst), .hub_suspended_i(hsus), .past_eof2_i(eof2),
      .upstream_tx_active_i(utx), .hs_negotiated_i(hs), .dev_connected_i(conn),
      .line_idle_i(idle), .remote_wake_i(wake), .se0_drive_o(se0),
      .port_reset_o(prst), .up_speed_hs_o(uhs), .up_resume_o(upres), .up_fault_o(upflt),
      .status_change_o(chg), .hub_char_o(hch), .port_power_enable_n_o(pwrn),
      .port_overcurrent_sense_n_i(ocn), .led_green_o(lg), .led_amber_o(la));
   hub_dev_model i_dev (.port_power_enable_n_i(pwrn), .dev_connected_o(conn),
      .port_overcurrent_sense_n_o(ocn), .attach_i(att), .fault_i(flt));
   task automatic finish_test;
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x)
      begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge mclk);
         if (pready === 1'b1)
            break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50)
         finish_test();
      // Idle edge so the next request never reassigns psel in this time step
      @(posedge mclk);
   endtask
   task automatic cmd(input logic [3:0] q, input logic [1:0] p, input logic [2:0] s);
      apb(CMD_OFS, 1'b1, {21'h0, s, 2'h0, p, q});
   endtask
   // Poll port 0 state with a bound
   task automatic wst(input logic [2:0] s);
      int i;
      for (i = 0; i < 200; i++)
      begin
         apb(STAT_OFS, 1'b0, 32'h0);
         if (r[2:0] === s)
            break;
      end
      chk(r[2:0], s);
      if (i == 200)
         finish_test();
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk({se0, pwrn}, 8'hff);
      chk(hch[7], 1'b1);
      foreach (rows[k])
      begin
         apb(rows[k].a, 1'b0, 32'h0);
         chk({e, r}, {rows[k].e, rows[k].d});
      end
      apb(CFG_OFS, 1'b1, CFG_RST | 32'h1);
      repeat (3) @(posedge mclk);
      chk(se0, 4'h0);
      chk(uhs, 1'b1);
      cmd(REQ_SET_POWER, 2'd0, 3'h0);
      att <= 4'h1;
      repeat (3) @(posedge mclk);
      chk({pwrn[0], chg[1]}, 2'b01);
      cmd(REQ_SET_RESET, 2'd0, 3'h0);
      @(posedge mclk);
      chk(prst[0], 1'b1);
      wst(PS_ENA);
      chk(lg[0], 1'b1);
      cmd(REQ_SET_SUSPEND, 2'd0, 3'h0);
      wst(PS_SUSP);
      hsus <= 1'b1;
      wake <= 4'h1;
      @(posedge mclk);
      wake <= 4'h0;
      @(posedge mclk);
      chk(upres, 1'b1);
      hsus <= 1'b0;
      wst(PS_ENA);
      cmd(REQ_SET_SUSPEND, 2'd0, 3'h0);
      wst(PS_SUSP);
      cmd(REQ_CLR_SUSPEND, 2'd0, 3'h0);
      wst(PS_ENA);
      cmd(REQ_CLR_ENABLE, 2'd0, 3'h0);
      wst(PS_DIS);
      cmd(REQ_SET_RESET, 2'd0, 3'h0);
      wst(PS_ENA);
      idle <= 4'he;
      eof2 <= 1'b1;
      utx <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(upflt, 1'b0);
      idle <= 4'hf;
      eof2 <= 1'b0;
      utx <= 1'b0;
      wst(PS_DIS);
      chk(lg[0], 1'b0);
      flt <= 4'h1;
      wst(PS_OFF);
      chk({pwrn[0], la[0]}, 2'b11);
      cmd(REQ_SET_IND, 2'd1, IND_GREEN);
      repeat (2) @(posedge mclk);
      chk(lg[1], 1'b1);
      bus_rst <= 1'b1;
      @(posedge mclk);
      bus_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(se0, 4'hf);
      finish_test();
   end
endmodule // tb_hub_downstream_port_control
